// ===== bench/trhc_src.sv
// Behavioural event source on the timer input pin, low while idle
`timescale 1ns/1ps
module trhc_src #(parameter int EVENTS = 5, parameter int HALF = 3) (
   // Clock, burst request and pin
   input  wire logic mclk_in,
   input  wire logic go_in,
   output logic      pin_out
);
   initial begin
      pin_out = 1'b0;
      forever @(posedge go_in) repeat (EVENTS) begin
         pin_out <= 1'b1;
         repeat (HALF) @(posedge mclk_in);
         pin_out <= 1'b0;
         repeat (HALF) @(posedge mclk_in);
      end
   end
endmodule : trhc_src

// ===== bench/trhc_sva.sv
// Checker bound to the timer top ports
`timescale 1ns/1ps
module trhc_sva import trhc_pkg::*; (
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // Watched inputs
   input  wire logic        ctrl_wr_in,
   input  wire logic        count_wr_in,
   input  trhc_ctrl_t       ctrl_in,
   // Watched outputs
   input  wire logic        running_out,
   input  wire logic        timer_status_signal_out,
   input  wire logic        timer_output_pin_out,
   input  wire logic        cpu_irq_out,
   input  wire logic        dma_sync_out,
   input  trhc_ctrl_t       ctrl_out,
   input  wire logic [31:0] timer_count_reg_out,
   input  wire logic [31:0] timer_period_reg_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   property p_rst; $past(rst_in) |-> !running_out && timer_count_reg_out == '0; endproperty
   a_rst: assert property (p_rst) else $error("not held after reset");
   property p_hold; !running_out && !count_wr_in |=> $stable(timer_count_reg_out); endproperty
   a_hold: assert property (p_hold) else $error("count moved in hold");
   property p_start; ctrl_wr_in && ctrl_in[8:7] == 2'h3 ##1 !ctrl_wr_in [*2] |->
      ##1 timer_count_reg_out == '0 && !ctrl_out.start_trigger_bit; endproperty
   a_start: assert property (p_start) else $error("start did not clear");
   property p_resv; ctrl_wr_in && ctrl_in[8:7] == 2'h2 ##1 !ctrl_wr_in |-> ##1 !running_out; endproperty
   a_resv: assert property (p_resv) else $error("reserved code ran");
   property p_resume; ctrl_wr_in && ctrl_in[8:7] == 2'h1 && !running_out ##1 !ctrl_wr_in |->
      ##1 running_out && $stable(timer_count_reg_out); endproperty
   a_resume: assert property (p_resume) else $error("resume failed");
   property p_wrap; running_out && timer_count_reg_out == timer_period_reg_out && !count_wr_in |=>
      timer_count_reg_out == '0; endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap at period");
   property p_irq; cpu_irq_out == timer_status_signal_out && dma_sync_out == timer_status_signal_out; endproperty
   a_irq: assert property (p_irq) else $error("event differs");
   property p_pin; timer_output_pin_out == (ctrl_out.output_func ?
      timer_status_signal_out ^ ctrl_out.invert_output : ctrl_out.output_data); endproperty
   a_pin: assert property (p_pin) else $error("bad output pin");
endmodule : trhc_sva
bind trhc_timer trhc_sva chk (
   .mclk_in                 (mclk_in),
   .rst_in                  (rst_in),
   .ctrl_wr_in              (ctrl_wr_in),
   .count_wr_in             (count_wr_in),
   .ctrl_in                 (ctrl_in),
   .running_out             (running_out),
   .timer_status_signal_out (timer_status_signal_out),
   .timer_output_pin_out    (timer_output_pin_out),
   .cpu_irq_out             (cpu_irq_out),
   .dma_sync_out            (dma_sync_out),
   .ctrl_out                (ctrl_out),
   .timer_count_reg_out     (timer_count_reg_out),
   .timer_period_reg_out    (timer_period_reg_out)
);

// ===== bench/trhc_timer_bench.sv
// Self-checking bench for the timer run/hold control block
`timescale 1ns/1ps
module trhc_timer_bench;
   import trhc_pkg::*;
   logic mclk_in = 1'b0, rst_in = 1'b1, div8_in = 1'b0, go = 1'b0, ctrl_wr_in = 1'b0, period_wr_in = 1'b0;
   logic count_wr_in = 1'b0, timer_status_signal_out, input_data_out, running_out, timer_input_pin_in;
   logic timer_output_pin_out, cpu_irq_out, dma_sync_out;
   logic [31:0] period_in = '0, count_in = '0, timer_period_reg_out, timer_count_reg_out, held;
   trhc_ctrl_t ctrl_in = '0, ctrl_out;
   int n_errors = 0, checks = 0, cyc = 0, g;
   trhc_timer dut (
      .mclk_in                 (mclk_in),
      .rst_in                  (rst_in),
      .div8_in                 (div8_in),
      .ctrl_wr_in              (ctrl_wr_in),
      .ctrl_in                 (ctrl_in),
      .period_wr_in            (period_wr_in),
      .period_in               (period_in),
      .count_wr_in             (count_wr_in),
      .count_in                (count_in),
      .ctrl_out                (ctrl_out),
      .timer_period_reg_out    (timer_period_reg_out),
      .timer_count_reg_out     (timer_count_reg_out),
      .timer_status_signal_out (timer_status_signal_out),
      .input_data_out          (input_data_out),
      .running_out             (running_out),
      .timer_input_pin_in      (timer_input_pin_in),
      .timer_output_pin_out    (timer_output_pin_out),
      .cpu_irq_out             (cpu_irq_out),
      .dma_sync_out            (dma_sync_out)
   );
   trhc_src src (.mclk_in, .go_in(go), .pin_out(timer_input_pin_in));
   initial forever #5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      n_errors += int'(++cyc == 3000);
      if (cyc == 3000) close_out;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : tick
   task automatic chk(input logic [31:0] a, e);
      checks++;
      n_errors += int'(a !== e);
      if (a !== e) $display("[ERR] %0t got %h exp %h", $time, a, e);
   endtask : chk
   // Spare edge after release so back-to-back calls never collide
   task automatic put(input logic [2:0] w, input logic [8:0] c, input logic [31:0] p, n);
      {ctrl_wr_in, period_wr_in, count_wr_in, ctrl_in, period_in, count_in} <= {w, c, p, n};
      tick(1);
      {ctrl_wr_in, period_wr_in, count_wr_in} <= 3'h0;
      tick(1);
   endtask : put
   task automatic gap(output int n);
      logic [31:0] v;
      v = timer_count_reg_out;
      for (n = 0; timer_count_reg_out === v && n < 99; n++) tick(1);
   endtask : gap
   // A count that never arrives shows up as a mismatch here, not as a silent fall-through
   task automatic wait_for(input logic [31:0] v);
      int n;
      for (n = 0; n < 400 && timer_count_reg_out !== v; n++) tick(1);
      chk(timer_count_reg_out, v);
   endtask : wait_for
   task automatic close_out;
      if (n_errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   initial begin
      for (int k = 0; k < 2; k++) begin
         {rst_in, div8_in} <= {1'b1, k[0]};
         tick(4);
         rst_in <= 1'b0;
         tick(1);
         chk(running_out, 0);
         chk(timer_count_reg_out, 0);
         put(3'h4, 9'h001, 0, 0);
         chk(timer_output_pin_out, 1);
         put(3'h3, 9'h000, 6, 7);
         put(3'h4, 9'h042, 0, 0);
         put(3'h4, 9'h1C2, 0, 0);
         // A mid-period value stands exactly one internal source period
         wait_for(3);
         gap(g);
         chk(g, k ? 8 : 4);
         wait_for(6);
         gap(g);
         chk(g, 1);
         chk(timer_count_reg_out, 0);
         chk(timer_status_signal_out, 1);
         chk(cpu_irq_out, 1);
         chk(dma_sync_out, 1);
         // Hold away from zero so a wrongly cleared resume cannot pass
         wait_for(3);
         put(3'h4, 9'h042, 0, 0);
         tick(2);
         held = timer_count_reg_out;
         tick(20);
         chk(timer_count_reg_out, held);
         chk(running_out, 0);
         chk(timer_status_signal_out, 0);
         put(3'h4, 9'h142, 0, 0);
         tick(20);
         chk(timer_count_reg_out, held);
         chk(running_out, 0);
         put(3'h4, 9'h0C2, 0, 0);
         gap(g);
         chk(timer_count_reg_out, held == 6 ? 0 : held + 1);
      end
      // Pin-clocked run in clock mode with inverted output: one toggle over five events
      put(3'h4, 9'h026, 0, 0);
      put(3'h3, 9'h026, 3, 0);
      put(3'h4, 9'h1A6, 0, 0);
      tick(4);
      go <= 1'b1;
      tick(3);
      chk(input_data_out, 1);
      tick(57);
      chk(timer_count_reg_out, 2);
      chk(timer_status_signal_out, 1);
      chk(timer_output_pin_out, 0);
      close_out;
   end
endmodule : trhc_timer_bench

// ===== core/trhc_edge.sv
// Clock source selection, internal divider and rising-edge count-enable generator
`timescale 1ns/1ps
module trhc_edge (
   // Clock and reset
   input  wire logic mclk_in,
   input  wire logic rst_in,
   // Configuration
   input  wire logic div8_in,
   input  wire logic src_internal_in,
   input  wire logic invert_in,
   input  wire logic pin_in,
   // Result
   output logic      pin_sync_out,
   output logic      count_en_out
);
   import trhc_pkg::*;

   logic [TRHC_DIV_W-1:0] div_reg, div_next;
   logic                  sync1_reg, sync2_reg, prev_reg, prev_next;
   logic                  sel;

   // Divider bit 1 (divide by 4) or msb (divide by 8) is a square wave at clock/4 or clock/8
   always_comb begin
      div_next = div_reg + 3'h1;
      if (!div8_in && div_reg >= TRHC_DIV4_MAX)
         div_next = 3'h0;
   end

   // Second flop feeds selection and pin_sync_out; first flop read only by the second flop
   always_comb begin
      sel = src_internal_in ? (div8_in ? div_reg[2] : div_reg[1]) : sync2_reg;
      sel = sel ^ invert_in;
      prev_next = sel;
   end

   assign count_en_out = sel & ~prev_reg;
   assign pin_sync_out = sync2_reg;

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         div_reg   <= 3'h0;
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg  <= 1'b0;
      end else begin
         div_reg   <= div_next;
         sync1_reg <= pin_in;
         sync2_reg <= sync1_reg;
         prev_reg  <= prev_next;
      end
   end
endmodule : trhc_edge

// ===== core/trhc_pkg.sv
// Package for the timer run/hold control block: constants, types and functional notes
// Functional notes
// - Timer has a 32-bit count register; measures time, counts events, makes pulses.
// - Two output modes; clocked from internal divided clock or external input.
// - Internal source is processor clock divided by 4 or by 8 per variant.
// - Input pin can clock the timer; output pin can show timer status.
// - Input pin may be general input; output pin may be general output.
// - Timer raises a processor interrupt and a DMA synchronization event.
// - On external clock the timer counts events, interrupting after programmed count.
// - Start bit 0 and release bit 0 hold the timer; counting disabled.
// - Start bit 0 and release bit 1 resume counting from held value.
// - Writing both bits 1 clears counter, then counts each enabled input event.
// - Start bit clears itself once the counter has been reset.
// - After reset the timer is held with counting disabled.
// - Counter equal to period returns to zero on next clock.
// - Each rising edge of selected input clock gives one-cycle count enable.
// - Source select 0 picks synchronized input pin, 1 picks internal divided clock.
// - Status drives interrupt and DMA event directly, same rate as status.
package trhc_pkg;
   localparam int          TRHC_CNT_W    = 32;
   localparam int          TRHC_DIV_W    = 3;
   localparam logic [2:0]  TRHC_DIV4_MAX = 3'h3;
   localparam logic [2:0]  TRHC_DIV8_MAX = 3'h7;
   localparam logic [31:0] TRHC_CNT_RST  = 32'h0000_0000;
   localparam logic [31:0] TRHC_PRD_RST  = 32'h0000_0000;
   localparam logic [31:0] TRHC_CNT_ONE  = 32'h0000_0001;

   // Control fields written by software
   typedef struct packed {
      logic start_trigger_bit;
      logic hold_release_bit;
      logic clock_source_select;  // 0 pin, 1 internal
      logic clock_mode;           // 0 pulse mode, 1 clock mode
      logic pulse_wide;           // pulse width two input periods
      logic invert_input;
      logic invert_output;
      logic output_func;          // 1 output pin shows status
      logic output_data;          // general output value
   } trhc_ctrl_t;

   typedef enum logic [1:0] {
      TRHC_HOLD  = 2'b00,
      TRHC_CLEAR = 2'b01,
      TRHC_RUN   = 2'b11
   } trhc_state_t;
endpackage : trhc_pkg

// ===== core/trhc_timer.sv
// Top of the 32-bit timer: run/hold control, counter, status and pin roles
`timescale 1ns/1ps
module trhc_timer (
   // Clock and reset
   input  wire logic                mclk_in,
   input  wire logic                rst_in,
   // Variant strap: 1 selects divide by 8
   input  wire logic                div8_in,
   // Software control
   input  wire logic                ctrl_wr_in,
   input  trhc_pkg::trhc_ctrl_t     ctrl_in,
   input  wire logic                period_wr_in,
   input  wire logic [31:0]         period_in,
   input  wire logic                count_wr_in,
   input  wire logic [31:0]         count_in,
   // Software status
   output trhc_pkg::trhc_ctrl_t     ctrl_out,
   output logic [31:0]              timer_period_reg_out,
   output logic [31:0]              timer_count_reg_out,
   output logic                     timer_status_signal_out,
   output logic                     input_data_out,
   output logic                     running_out,
   // Pins
   input  wire logic                timer_input_pin_in,
   output logic                     timer_output_pin_out,
   // Events
   output logic                     cpu_irq_out,
   output logic                     dma_sync_out
);
   import trhc_pkg::*;

   trhc_ctrl_t    timer_control_reg, timer_control_next;
   logic [31:0]   timer_period_reg, timer_period_next;
   logic [31:0]   timer_count_reg, timer_count_next;
   trhc_state_t   state_reg, state_next;
   logic          status_reg, status_next;
   logic          wide_reg, wide_next;
   logic          pin_sync;
   logic          count_en;
   logic          at_period;

   trhc_edge u_edge (
      .mclk_in         (mclk_in),
      .rst_in          (rst_in),
      .div8_in         (div8_in),
      .src_internal_in (timer_control_reg.clock_source_select),
      .invert_in       (timer_control_reg.invert_input),
      .pin_in          (timer_input_pin_in),
      .pin_sync_out    (pin_sync),
      .count_en_out    (count_en)
   );

   assign at_period = (timer_count_reg == timer_period_reg);

   // Run/hold decode from the two control bits
   always_comb begin
      state_next         = state_reg;
      timer_control_next = timer_control_reg;
      timer_period_next  = period_wr_in ? period_in : timer_period_reg;
      if (ctrl_wr_in)
         timer_control_next = ctrl_in;
      case (state_reg)
         TRHC_HOLD, TRHC_RUN: begin
            if (timer_control_reg.start_trigger_bit && timer_control_reg.hold_release_bit)
               state_next = TRHC_CLEAR;
            else if (timer_control_reg.hold_release_bit)
               state_next = TRHC_RUN;
            else
               state_next = TRHC_HOLD;
         end
         TRHC_CLEAR: begin
            state_next = timer_control_reg.hold_release_bit ? TRHC_RUN : TRHC_HOLD;
            // Self-clear unless software rewrites the bit in this same cycle
            if (!ctrl_wr_in)
               timer_control_next.start_trigger_bit = 1'b0;
         end
         default: state_next = TRHC_HOLD;
      endcase
   end

   // Counter; software count write overrides hardware update
   always_comb begin
      timer_count_next = timer_count_reg;
      status_next      = status_reg;
      wide_next        = wide_reg;
      if (state_reg == TRHC_CLEAR) begin
         timer_count_next = TRHC_CNT_RST;
      end else if (state_reg == TRHC_RUN && at_period) begin
         // Match clears on the next clock, not the next enable, so the period is N input clocks
         // An enable in the match cycle is dropped; enables are always at least two clocks apart
         timer_count_next = TRHC_CNT_RST;
         if (timer_control_reg.clock_mode)
            status_next = ~status_reg;
         else begin
            status_next = 1'b1;
            wide_next   = timer_control_reg.pulse_wide;
         end
      end else if (state_reg == TRHC_RUN && count_en) begin
         // Above period the counter wraps through all ones
         timer_count_next = timer_count_reg + TRHC_CNT_ONE;
         wide_next        = 1'b0;
         if (!timer_control_reg.clock_mode)
            status_next = wide_reg;
      end
      if (count_wr_in)
         timer_count_next = count_in;
   end

   // Pin roles and events
   assign timer_output_pin_out    = timer_control_reg.output_func ?
                                    (status_reg ^ timer_control_reg.invert_output) :
                                    timer_control_reg.output_data;
   assign input_data_out          = pin_sync;
   assign cpu_irq_out             = status_reg;
   assign dma_sync_out            = status_reg;
   assign timer_status_signal_out = status_reg;
   assign ctrl_out                = timer_control_reg;
   assign timer_period_reg_out    = timer_period_reg;
   assign timer_count_reg_out     = timer_count_reg;
   assign running_out             = (state_reg != TRHC_HOLD);

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         timer_control_reg <= '0;
         timer_period_reg  <= TRHC_PRD_RST;
         timer_count_reg   <= TRHC_CNT_RST;
         state_reg         <= TRHC_HOLD;
         status_reg        <= 1'b0;
         wide_reg          <= 1'b0;
      end else begin
         timer_control_reg <= timer_control_next;
         timer_period_reg  <= timer_period_next;
         timer_count_reg   <= timer_count_next;
         state_reg         <= state_next;
         status_reg        <= status_next;
         wide_reg          <= wide_next;
      end
   end
endmodule : trhc_timer
